// ---- logic/aorb_pkg.sv ----
// constants and types of the analog override register bank
package aorb_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [6:0] AORB_ADDR_COARSE = 7'h63;
  localparam logic [6:0] AORB_ADDR_FINE   = 7'h64;
  localparam logic [6:0] AORB_ADDR_REGEN  = 7'h65;
  localparam logic [6:0] AORB_ADDR_LEVEL  = 7'h66;
  localparam logic [6:0] AORB_ADDR_TUNE1  = 7'h67;
  localparam logic [6:0] AORB_ADDR_TUNE2  = 7'h68;
  localparam logic [6:0] AORB_ADDR_GAIN   = 7'h69;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] AORB_RST_COARSE = 8'h00;
  localparam logic [7:0] AORB_RST_FINE   = 8'h00;
  localparam logic [7:0] AORB_RST_REGEN  = 8'h81;
  localparam logic [7:0] AORB_RST_LEVEL  = 8'h00;
  localparam logic [7:0] AORB_RST_TUNE1  = 8'h1d;
  localparam logic [7:0] AORB_RST_TUNE2  = 8'h00;
  localparam logic [7:0] AORB_RST_GAIN   = 8'h20;

  // ************************************************************
  // writable bit masks, reserved bits are zero
  // ************************************************************
  localparam logic [7:0] AORB_MASK_FULL  = 8'hff;
  localparam logic [7:0] AORB_MASK_LEVEL = 8'hf7;
  localparam logic [7:0] AORB_MASK_TUNE2 = 8'h1f;
  localparam logic [7:0] AORB_MASK_GAIN  = 8'h3f;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int AORB_BIT_CAL_OVR   = 7;
  localparam int AORB_BIT_SPOR      = 7;
  localparam int AORB_BIT_DIGPWDN   = 0;
  localparam int AORB_BIT_ENOVR     = 7;
  localparam int AORB_BIT_ADCRST    = 7;
  localparam int AORB_BIT_REFDAC    = 6;
  localparam int AORB_BIT_ADCEN     = 5;
  localparam int AORB_BIT_TUNEOVR   = 4;
  localparam int AORB_BIT_VCM       = 4;
  localparam int AORB_BIT_OLOOP     = 3;
  localparam int AORB_BIT_AGCEN     = 5;
  localparam int AORB_BIT_LNA       = 4;
  localparam int AORB_NBLK          = 9;

  // ************************************************************
  // codes
  // ************************************************************
  localparam logic [2:0] AORB_ADCREF_0V5 = 3'h0;
  localparam logic [2:0] AORB_ADCREF_0V6 = 3'h1;
  localparam logic [2:0] AORB_ADCREF_0V7 = 3'h2;
  localparam logic [2:0] AORB_ADCREF_1V2 = 3'h7;
  localparam logic       AORB_LNA_5DB    = 1'b0;
  localparam logic       AORB_LNA_25DB   = 1'b1;
  localparam logic [3:0] AORB_PGA_0DB    = 4'h0;
  localparam logic [3:0] AORB_PGA_3DB    = 4'h1;
  localparam logic [3:0] AORB_PGA_6DB    = 4'h2;
  localparam logic [3:0] AORB_PGA_24DB   = 4'h5;

  // ************************************************************
  // bank state
  // ************************************************************
  typedef struct packed {
    logic [7:0]           coarse;
    logic [7:0]           fine;
    logic [7:0]           regen;
    logic [7:0]           level;
    logic [7:0]           tune1;
    logic [7:0]           tune2;
    logic [7:0]           gain;
    logic [7:0]           rdata;
    logic                 rvalid;
    logic [6:0]           rc_coarse;
    logic [6:0]           rc_fine;
    logic [AORB_NBLK-1:0] blk_en;
    logic                 spor_en;
    logic                 dig_pwdn;
    logic [2:0]           dig_lvl;
    logic                 adc_rst;
    logic                 adc_refdac_en;
    logic                 adc_en;
    logic [3:0]           adc_tune;
    logic                 adc_vcm_en;
    logic                 adc_oloop;
    logic [2:0]           adc_ref;
    logic                 agc_en;
    logic                 lna_max;
    logic [3:0]           pga;
  } aorb_state_type;

endpackage

// ---- logic/aorb_ovr_if.sv ----
// carrier between the register bank and its override selector
`timescale 1ns/1ns
interface aorb_ovr_if;
  import aorb_pkg::*;
  logic [7:0]           coarse_reg;
  logic [7:0]           fine_reg;
  logic [7:0]           regen_reg;
  logic [7:0]           level_reg;
  logic [7:0]           tune1_reg;
  logic [7:0]           gain_reg;
  logic [6:0]           cal_coarse;
  logic [6:0]           cal_fine;
  logic [3:0]           cal_tune;
  logic                 agc_lna;
  logic [3:0]           agc_pga;
  logic [AORB_NBLK-1:0] auto_en;
  logic [6:0]           eff_coarse;
  logic [6:0]           eff_fine;
  logic [3:0]           eff_tune;
  logic                 eff_lna;
  logic [3:0]           eff_pga;
  logic [AORB_NBLK-1:0] eff_blk;
  logic [7:0]           rd_coarse;
  logic [7:0]           rd_fine;
  logic [7:0]           rd_gain;

  modport mux (
    input  coarse_reg, fine_reg, regen_reg, level_reg, tune1_reg, gain_reg,
    input  cal_coarse, cal_fine, cal_tune, agc_lna, agc_pga, auto_en,
    output eff_coarse, eff_fine, eff_tune, eff_lna, eff_pga, eff_blk,
    output rd_coarse, rd_fine, rd_gain
  );
  modport bank (
    output coarse_reg, fine_reg, regen_reg, level_reg, tune1_reg, gain_reg,
    output cal_coarse, cal_fine, cal_tune, agc_lna, agc_pga, auto_en,
    input  eff_coarse, eff_fine, eff_tune, eff_lna, eff_pga, eff_blk,
    input  rd_coarse, rd_fine, rd_gain
  );
endinterface

// ---- logic/aorb_ovr_mux.sv ----
// override selection between written values and internal results
`timescale 1ns/1ns
module aorb_ovr_mux
  import aorb_pkg::*;
(
  aorb_ovr_if.mux ovr
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [6:0] cal_sel(input logic ov, input logic [6:0] wr,
                                         input logic [6:0] cal);
    cal_sel = ov ? wr : cal;
  endfunction

  function automatic logic [3:0] pga_clamp(input logic [3:0] code);
    pga_clamp = (code > AORB_PGA_24DB) ? AORB_PGA_24DB : code;
  endfunction

  logic [AORB_NBLK-1:0] ovr_vals;
  logic                 cov;
  logic                 fov;
  logic                 agc;

  // ************************************************************
  // selection
  // ************************************************************
  always_comb begin
    cov        = ovr.coarse_reg[AORB_BIT_CAL_OVR];
    fov        = ovr.fine_reg[AORB_BIT_CAL_OVR];
    agc        = ovr.gain_reg[AORB_BIT_AGCEN];
    ovr.eff_coarse = cal_sel(cov, ovr.coarse_reg[6:0], ovr.cal_coarse);
    ovr.eff_fine   = cal_sel(fov, ovr.fine_reg[6:0], ovr.cal_fine);
    ovr.eff_tune   = ovr.tune1_reg[AORB_BIT_TUNEOVR] ? ovr.tune1_reg[3:0]
                                                     : ovr.cal_tune;
    ovr.rd_coarse  = {cov, cal_sel(cov, ovr.coarse_reg[6:0], ovr.cal_coarse)};
    ovr.rd_fine    = {fov, cal_sel(fov, ovr.fine_reg[6:0], ovr.cal_fine)};
    ovr.eff_lna    = agc ? ovr.agc_lna : ovr.gain_reg[AORB_BIT_LNA];
    ovr.eff_pga    = pga_clamp(agc ? ovr.agc_pga : ovr.gain_reg[3:0]);
    ovr.rd_gain    = agc ? {2'b00, agc, ovr.agc_lna, ovr.agc_pga}
                         : (ovr.gain_reg & AORB_MASK_GAIN);
    ovr_vals       = {ovr.level_reg[6:4], ovr.regen_reg[6:1]};
    ovr.eff_blk    = ovr.level_reg[AORB_BIT_ENOVR] ? ovr_vals
                                                   : (ovr_vals | ovr.auto_en);
  end

endmodule

// ---- logic/aorb_bank.sv ----
// analog override register bank top
`timescale 1ns/1ns
// Overview of operation
// - With the coarse override flag clear, the coarse field reads back the internal result.
// - With the coarse override flag set, the written coarse value drives the oscillator.
// - With the fine override flag clear, the fine field reads back the internal result.
// - With the fine override flag set, the written fine value drives the oscillator.
// - After reset the regulator register holds only smart reset and idle power-down set.
// - The idle power-down bit powers down the digital domain while the device idles.
// - Global override high lets overrides enable and disable, low lets them only enable.
// - Bits 2 to 0 of the level register select the digital regulator level.
// - With tuning override set the written 4-bit value replaces the calibrated one.
// - After reset the ADC tuning register holds override on, value 1101, others clear.
// - The 3-bit ADC reference field selects the reference voltage code.
// - With AGC on the loop gain is readable, with AGC off the host writes the gain.
// - The LNA gain bit picks 5 dB at zero and 25 dB at one.
// - The PGA field codes 0, 3, 6 dB upward with 101 as the 24 dB maximum.
// - The open-loop bit places the delta-sigma ADC in open-loop operation.
module aorb_bank
  import aorb_pkg::*;
(
  // clock and reset
  input  wire logic                 I_CLK_SYS,
  input  wire logic                 I_RST,
  // register access
  input  wire logic                 I_REG_WR,
  input  wire logic                 I_REG_RD,
  input  wire logic [6:0]           I_REG_ADDR,
  input  wire logic [7:0]           I_REG_WDATA,
  output logic      [7:0]           O_REG_RDATA,
  output logic                      O_REG_RVALID,
  // internal calibration and loop results
  input  wire logic [6:0]           I_CAL_COARSE,
  input  wire logic [6:0]           I_CAL_FINE,
  input  wire logic [3:0]           I_CAL_ADC_TUNE,
  input  wire logic                 I_AGC_LNA,
  input  wire logic [3:0]           I_AGC_PGA,
  // device state
  input  wire logic                 I_IDLE_MODE,
  input  wire logic [AORB_NBLK-1:0] I_AUTO_EN,
  // oscillator controls
  output logic      [6:0]           O_RC_COARSE,
  output logic      [6:0]           O_RC_FINE,
  // regulator controls
  output logic                      O_SPOR_EN,
  output logic      [AORB_NBLK-1:0] O_BLK_EN,
  output logic                      O_DIG_PWDN,
  output logic      [2:0]           O_DIG_LVL,
  // adc controls
  output logic                      O_ADC_RST,
  output logic                      O_ADC_REFDAC_EN,
  output logic                      O_ADC_EN,
  output logic      [3:0]           O_ADC_TUNE,
  output logic                      O_ADC_VCM_EN,
  output logic                      O_ADC_OPEN_LOOP,
  output logic      [2:0]           O_ADC_REF,
  // gain controls
  output logic                      O_AGC_EN,
  output logic                      O_LNA_GAIN_MAX,
  output logic      [3:0]           O_PGA_GAIN
);

  // ************************************************************
  // state
  // ************************************************************
  aorb_state_type state_ff;
  aorb_state_type nxt_state;
  logic           wr_coarse;
  logic           wr_fine;
  logic           wr_regen;
  logic           wr_level;
  logic           wr_tune1;
  logic           wr_tune2;
  logic           wr_gain;
  logic [7:0]     rd_value;

  aorb_ovr_if ovr ();

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [7:0] masked(input logic [7:0] data, input logic [7:0] mask);
    masked = data & mask;
  endfunction

  function automatic aorb_state_type reset_state();
    aorb_state_type s;
    s               = '0;
    s.coarse        = AORB_RST_COARSE;
    s.fine          = AORB_RST_FINE;
    s.regen         = AORB_RST_REGEN;
    s.level         = AORB_RST_LEVEL;
    s.tune1         = AORB_RST_TUNE1;
    s.tune2         = AORB_RST_TUNE2;
    s.gain          = AORB_RST_GAIN;
    s.spor_en       = AORB_RST_REGEN[AORB_BIT_SPOR];
    s.adc_tune      = AORB_RST_TUNE1[3:0];
    s.agc_en        = AORB_RST_GAIN[AORB_BIT_AGCEN];
    s.lna_max       = AORB_LNA_5DB;
    s.pga           = AORB_PGA_0DB;
    s.adc_ref       = AORB_ADCREF_0V5;
    reset_state     = s;
  endfunction

  // ************************************************************
  // override selector
  // ************************************************************
  assign ovr.coarse_reg = state_ff.coarse;
  assign ovr.fine_reg   = state_ff.fine;
  assign ovr.regen_reg  = state_ff.regen;
  assign ovr.level_reg  = state_ff.level;
  assign ovr.tune1_reg  = state_ff.tune1;
  assign ovr.gain_reg   = state_ff.gain;
  assign ovr.cal_coarse = I_CAL_COARSE;
  assign ovr.cal_fine   = I_CAL_FINE;
  assign ovr.cal_tune   = I_CAL_ADC_TUNE;
  assign ovr.agc_lna    = I_AGC_LNA;
  assign ovr.agc_pga    = I_AGC_PGA;
  assign ovr.auto_en    = I_AUTO_EN;

  aorb_ovr_mux u_ovr_mux (
    .ovr (ovr.mux)
  );

  // ************************************************************
  // address decode
  // ************************************************************
  always_comb begin
    wr_coarse = 1'b0;
    wr_fine   = 1'b0;
    wr_regen  = 1'b0;
    wr_level  = 1'b0;
    wr_tune1  = 1'b0;
    wr_tune2  = 1'b0;
    wr_gain   = 1'b0;
    rd_value  = 8'h00;
    if (I_REG_ADDR == AORB_ADDR_COARSE) begin
      wr_coarse = I_REG_WR;
      rd_value  = ovr.rd_coarse;
    end else if (I_REG_ADDR == AORB_ADDR_FINE) begin
      wr_fine   = I_REG_WR;
      rd_value  = ovr.rd_fine;
    end else if (I_REG_ADDR == AORB_ADDR_REGEN) begin
      wr_regen  = I_REG_WR;
      rd_value  = state_ff.regen;
    end else if (I_REG_ADDR == AORB_ADDR_LEVEL) begin
      wr_level  = I_REG_WR;
      rd_value  = masked(state_ff.level, AORB_MASK_LEVEL);
    end else if (I_REG_ADDR == AORB_ADDR_TUNE1) begin
      wr_tune1  = I_REG_WR;
      rd_value  = state_ff.tune1;
    end else if (I_REG_ADDR == AORB_ADDR_TUNE2) begin
      wr_tune2  = I_REG_WR;
      rd_value  = masked(state_ff.tune2, AORB_MASK_TUNE2);
    end else if (I_REG_ADDR == AORB_ADDR_GAIN) begin
      wr_gain   = I_REG_WR;
      rd_value  = ovr.rd_gain;
    end else begin
      rd_value  = 8'h00;
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    nxt_state = state_ff;
    // register writes
    if (wr_coarse) begin
      nxt_state.coarse = masked(I_REG_WDATA, AORB_MASK_FULL);
    end
    if (wr_fine) begin
      nxt_state.fine = masked(I_REG_WDATA, AORB_MASK_FULL);
    end
    if (wr_regen) begin
      nxt_state.regen = masked(I_REG_WDATA, AORB_MASK_FULL);
    end
    if (wr_level) begin
      nxt_state.level = masked(I_REG_WDATA, AORB_MASK_LEVEL);
    end
    if (wr_tune1) begin
      nxt_state.tune1 = masked(I_REG_WDATA, AORB_MASK_FULL);
    end
    if (wr_tune2) begin
      nxt_state.tune2 = masked(I_REG_WDATA, AORB_MASK_TUNE2);
    end
    if (wr_gain) begin
      nxt_state.gain = masked(I_REG_WDATA, AORB_MASK_GAIN);
    end
    // read data
    nxt_state.rvalid = I_REG_RD;
    if (I_REG_RD) begin
      nxt_state.rdata = rd_value;
    end
    // oscillator calibration
    nxt_state.rc_coarse     = ovr.eff_coarse;
    nxt_state.rc_fine       = ovr.eff_fine;
    // regulators
    nxt_state.spor_en       = state_ff.regen[AORB_BIT_SPOR];
    nxt_state.blk_en        = ovr.eff_blk;
    nxt_state.dig_pwdn      = state_ff.regen[AORB_BIT_DIGPWDN] & I_IDLE_MODE;
    nxt_state.dig_lvl       = state_ff.level[2:0];
    // delta-sigma adc
    nxt_state.adc_rst       = state_ff.tune1[AORB_BIT_ADCRST];
    nxt_state.adc_refdac_en = state_ff.tune1[AORB_BIT_REFDAC];
    nxt_state.adc_en        = state_ff.tune1[AORB_BIT_ADCEN];
    nxt_state.adc_tune      = ovr.eff_tune;
    nxt_state.adc_vcm_en    = state_ff.tune2[AORB_BIT_VCM];
    nxt_state.adc_oloop     = state_ff.tune2[AORB_BIT_OLOOP];
    nxt_state.adc_ref       = state_ff.tune2[2:0];
    // gain
    nxt_state.agc_en        = state_ff.gain[AORB_BIT_AGCEN];
    nxt_state.lna_max       = ovr.eff_lna;
    nxt_state.pga           = ovr.eff_pga;
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      state_ff <= reset_state();
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign O_REG_RDATA     = state_ff.rdata;
  assign O_REG_RVALID    = state_ff.rvalid;
  assign O_RC_COARSE     = state_ff.rc_coarse;
  assign O_RC_FINE       = state_ff.rc_fine;
  assign O_SPOR_EN       = state_ff.spor_en;
  assign O_BLK_EN        = state_ff.blk_en;
  assign O_DIG_PWDN      = state_ff.dig_pwdn;
  assign O_DIG_LVL       = state_ff.dig_lvl;
  assign O_ADC_RST       = state_ff.adc_rst;
  assign O_ADC_REFDAC_EN = state_ff.adc_refdac_en;
  assign O_ADC_EN        = state_ff.adc_en;
  assign O_ADC_TUNE      = state_ff.adc_tune;
  assign O_ADC_VCM_EN    = state_ff.adc_vcm_en;
  assign O_ADC_OPEN_LOOP = state_ff.adc_oloop;
  assign O_ADC_REF       = state_ff.adc_ref;
  assign O_AGC_EN        = state_ff.agc_en;
  assign O_LNA_GAIN_MAX  = state_ff.lna_max;
  assign O_PGA_GAIN      = state_ff.pga;

endmodule

// ---- dv/aorb_bank_monitor.sv ----
// concurrent checks on the ports of the analog override register bank
`timescale 1ns/1ns
module aorb_bank_chk
  import aorb_pkg::*;
(
  // clock and reset
  input wire logic                 I_CLK_SYS,
  input wire logic                 I_RST,
  // register access
  input wire logic                 I_REG_WR,
  input wire logic                 I_REG_RD,
  input wire logic [6:0]           I_REG_ADDR,
  input wire logic [7:0]           I_REG_WDATA,
  input wire logic [7:0]           O_REG_RDATA,
  input wire logic                 O_REG_RVALID,
  // internal results and state
  input wire logic [6:0]           I_CAL_COARSE,
  input wire logic [3:0]           I_CAL_ADC_TUNE,
  input wire logic                 I_IDLE_MODE,
  input wire logic [AORB_NBLK-1:0] I_AUTO_EN,
  // controls
  input wire logic [6:0]           O_RC_COARSE,
  input wire logic [AORB_NBLK-1:0] O_BLK_EN,
  input wire logic                 O_DIG_PWDN,
  input wire logic [3:0]           O_ADC_TUNE,
  input wire logic                 O_SPOR_EN,
  input wire logic [3:0]           O_PGA_GAIN
);
  logic       cov_ff;
  logic [6:0] cval_ff;
  logic       tov_ff;
  logic [3:0] tval_ff;
  logic       enovr_ff;

  // ************************************************************
  // shadow of override flags
  // ************************************************************
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      cov_ff   <= 1'b0;
      cval_ff  <= 7'h00;
      tov_ff   <= 1'b1;
      tval_ff  <= AORB_RST_TUNE1[3:0];
      enovr_ff <= 1'b0;
    end else if (I_REG_WR) begin
      case (I_REG_ADDR)
        AORB_ADDR_COARSE: begin
          cov_ff  <= I_REG_WDATA[7];
          cval_ff <= I_REG_WDATA[6:0];
        end
        AORB_ADDR_TUNE1: begin
          tov_ff  <= I_REG_WDATA[4];
          tval_ff <= I_REG_WDATA[3:0];
        end
        AORB_ADDR_LEVEL: begin
          enovr_ff <= I_REG_WDATA[7];
        end
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  rvalid_pulse_a: assert property ((I_REG_RD ##1 !I_REG_RD) |-> O_REG_RVALID ##1 !O_REG_RVALID)
    else $error("read valid pulse wrong");
  rvalid_idle_a: assert property (!I_REG_RD |=> !O_REG_RVALID)
    else $error("read valid without read");
  unmapped_zero_a: assert property ((I_REG_RD && (I_REG_ADDR < AORB_ADDR_COARSE ||
    I_REG_ADDR > AORB_ADDR_GAIN)) |=> O_REG_RDATA == 8'h00) else $error("unmapped read not zero");
  reserved_zero_a: assert property ((I_REG_RD && I_REG_ADDR == AORB_ADDR_TUNE2)
    |=> O_REG_RDATA[7:5] == 3'h0) else $error("reserved bits not zero");
  coarse_follow_a: assert property (!cov_ff |=> O_RC_COARSE == $past(I_CAL_COARSE))
    else $error("coarse not from calibration");
  coarse_ovr_a: assert property (cov_ff |=> O_RC_COARSE == $past(cval_ff))
    else $error("coarse override not applied");
  tune_select_a: assert property (1'b1 |=> O_ADC_TUNE ==
    ($past(tov_ff) ? $past(tval_ff) : $past(I_CAL_ADC_TUNE))) else $error("tune select wrong");
  enable_only_a: assert property (!enovr_ff |=>
    (O_BLK_EN & $past(I_AUTO_EN)) == $past(I_AUTO_EN)) else $error("auto enable lost");
  idle_pwdn_a: assert property (!I_IDLE_MODE |=> !O_DIG_PWDN)
    else $error("power down outside idle");
  pga_ceiling_a: assert property (O_PGA_GAIN <= 4'h5)
    else $error("pga above maximum");
  reset_value_a: assert property (@(posedge I_CLK_SYS) disable iff (1'b0)
    I_RST |=> (O_SPOR_EN && O_ADC_TUNE == 4'hd && !O_REG_RVALID)) else $error("reset value wrong");

  read_seen_c: cover property (I_REG_RD ##1 O_REG_RVALID);
  coarse_ovr_c: cover property (cov_ff && I_CAL_COARSE != cval_ff);
  enovr_c: cover property (enovr_ff && |I_AUTO_EN);
endmodule

bind aorb_bank aorb_bank_chk u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST),
  .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .I_REG_ADDR(I_REG_ADDR),
  .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA), .O_REG_RVALID(O_REG_RVALID),
  .I_CAL_COARSE(I_CAL_COARSE), .I_CAL_ADC_TUNE(I_CAL_ADC_TUNE), .I_IDLE_MODE(I_IDLE_MODE),
  .I_AUTO_EN(I_AUTO_EN), .O_RC_COARSE(O_RC_COARSE), .O_BLK_EN(O_BLK_EN),
  .O_DIG_PWDN(O_DIG_PWDN), .O_ADC_TUNE(O_ADC_TUNE), .O_SPOR_EN(O_SPOR_EN),
  .O_PGA_GAIN(O_PGA_GAIN));

// ---- dv/aorb_host_model.sv ----
// host side model issuing register writes and reads
`timescale 1ns/1ns
module aorb_host_model (
  // clock
  input  wire logic       i_clk,
  // register access
  output logic            o_wr,
  output logic            o_rd,
  output logic [6:0]      o_addr,
  output logic [7:0]      o_wdata,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 7'h00;
    o_wdata = 8'h00;
  end

  // request held over one rising edge, released lines toggled
  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask

  task automatic read_reg(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    d = i_rdata;
    v = i_rvalid;
    o_rd = 1'b0;
    o_addr = ~a;
  endtask
endmodule

// ---- dv/aorb_bank_tb_top.sv ----
// self-checking testbench of the analog override register bank
`timescale 1ns/1ns
module aorb_bank_tb_top;
  import aorb_pkg::*;
  logic       clk = 1'b0;
  logic       rst, wr, rd, rvalid, agc_lna, idle, spor, dig_pwdn;
  logic       adc_rst, refdac, adc_en, vcm, oloop, agc_en, lna_max;
  logic [6:0] addr, cal_c, cal_f, rc_c, rc_f;
  logic [7:0] wdata, rdata;
  logic [3:0] cal_t, agc_pga, adc_tune, pga;
  logic [8:0] auto_en, blk_en;
  logic [2:0] dig_lvl, adc_ref;
  int         err_count, compares, cycles;

  always #50 clk = ~clk;

  aorb_host_model host (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata),
    .i_rdata(rdata), .i_rvalid(rvalid));

  aorb_bank dut (.I_CLK_SYS(clk), .I_RST(rst), .I_REG_WR(wr), .I_REG_RD(rd),
    .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
    .I_CAL_COARSE(cal_c), .I_CAL_FINE(cal_f), .I_CAL_ADC_TUNE(cal_t), .I_AGC_LNA(agc_lna),
    .I_AGC_PGA(agc_pga), .I_IDLE_MODE(idle), .I_AUTO_EN(auto_en), .O_RC_COARSE(rc_c),
    .O_RC_FINE(rc_f), .O_SPOR_EN(spor), .O_BLK_EN(blk_en), .O_DIG_PWDN(dig_pwdn),
    .O_DIG_LVL(dig_lvl), .O_ADC_RST(adc_rst), .O_ADC_REFDAC_EN(refdac), .O_ADC_EN(adc_en),
    .O_ADC_TUNE(adc_tune), .O_ADC_VCM_EN(vcm), .O_ADC_OPEN_LOOP(oloop), .O_ADC_REF(adc_ref),
    .O_AGC_EN(agc_en), .O_LNA_GAIN_MAX(lna_max), .O_PGA_GAIN(pga));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task complete_run;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task step;
    @(negedge clk);
  endtask

  task rdchk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    host.read_reg(a, d, v);
    chk("rvalid", {8'h00, v}, 9'h001);
    chk("rdata", {1'b0, d}, {1'b0, exp});
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task t_reset;
    rdchk(AORB_ADDR_COARSE, {1'b0, cal_c});
    rdchk(AORB_ADDR_FINE, {1'b0, cal_f});
    rdchk(AORB_ADDR_REGEN, 8'h81);
    rdchk(AORB_ADDR_TUNE1, 8'h1d);
    rdchk(AORB_ADDR_GAIN, {3'h1, agc_lna, agc_pga});
    chk("spor", {8'h00, spor}, 9'h001);
    chk("adc_tune", {5'h00, adc_tune}, 9'h00d);
  endtask

  task t_rc;
    logic [6:0] a;
    for (int i = 0; i < 2; i++) begin
      a = (i == 0) ? AORB_ADDR_COARSE : AORB_ADDR_FINE;
      host.write_reg(a, 8'ha5);
      step();
      chk("rc", {2'h0, (i == 0) ? rc_c : rc_f}, 9'h025);
      rdchk(a, 8'ha5);
      cal_c = 7'h11;
      cal_f = 7'h6e;
      step();
      chk("rc held", {2'h0, (i == 0) ? rc_c : rc_f}, 9'h025);
      host.write_reg(a, 8'h25);
      step();
      chk("rc cal", {2'h0, i ? rc_f : rc_c}, {2'h0, i ? cal_f : cal_c});
      rdchk(a, {1'b0, (i == 0) ? cal_c : cal_f});
    end
  endtask

  task t_reg;
    auto_en = 9'h083;
    host.write_reg(AORB_ADDR_LEVEL, 8'h5d);
    host.write_reg(AORB_ADDR_REGEN, 8'h55);
    step();
    chk("blk_en", blk_en, 9'h1eb);
    chk("dig_lvl", {6'h00, dig_lvl}, 9'h005);
    chk("dig_pwdn", {8'h00, dig_pwdn}, 9'h000);
    rdchk(AORB_ADDR_LEVEL, 8'h55);
    idle = 1'b1;
    step();
    chk("dig_pwdn", {8'h00, dig_pwdn}, 9'h001);
    host.write_reg(AORB_ADDR_LEVEL, 8'hd5);
    step();
    chk("blk_en", blk_en, 9'h16a);
    host.write_reg(AORB_ADDR_REGEN, 8'h54);
    step();
    chk("dig_pwdn", {8'h00, dig_pwdn}, 9'h000);
    idle = 1'b0;
  endtask

  task t_adc;
    logic [2:0] codes [4];
    logic [7:0] d;
    codes = '{AORB_ADCREF_0V5, AORB_ADCREF_0V6, AORB_ADCREF_0V7, AORB_ADCREF_1V2};
    cal_t = 4'h6;
    host.write_reg(AORB_ADDR_TUNE1, 8'he3);
    step();
    chk("adc_tune", {5'h00, adc_tune}, 9'h006);
    chk("adc ctl", {6'h00, adc_rst, refdac, adc_en}, 9'h007);
    host.write_reg(AORB_ADDR_TUNE1, 8'h17);
    cal_t = 4'h9;
    step();
    chk("adc_tune", {5'h00, adc_tune}, 9'h007);
    chk("adc ctl", {6'h00, adc_rst, refdac, adc_en}, 9'h000);
    for (int i = 0; i < 4; i++) begin
      d = {3'h7, i[0], i[0], codes[i]};
      host.write_reg(AORB_ADDR_TUNE2, d);
      step();
      chk("adc_ref", {6'h00, adc_ref}, {6'h00, codes[i]});
      chk("open_loop", {8'h00, oloop}, {8'h00, i[0]});
      chk("vcm", {8'h00, vcm}, {8'h00, i[0]});
      rdchk(AORB_ADDR_TUNE2, d & 8'h1f);
    end
  endtask

  task t_gain;
    logic [3:0] codes [5];
    logic [3:0] exps [5];
    codes = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h7};
    exps = '{AORB_PGA_0DB, AORB_PGA_3DB, AORB_PGA_6DB, AORB_PGA_24DB, AORB_PGA_24DB};
    for (int i = 0; i < 5; i++) begin
      host.write_reg(AORB_ADDR_GAIN, {3'h6, i[0], codes[i]});
      step();
      chk("agc_en", {8'h00, agc_en}, 9'h000);
      chk("lna", {8'h00, lna_max}, {8'h00, i[0]});
      chk("pga", {5'h00, pga}, {5'h00, exps[i]});
      rdchk(AORB_ADDR_GAIN, {3'h0, i[0], codes[i]});
    end
    host.write_reg(AORB_ADDR_GAIN, 8'h20);
    agc_lna = 1'b1;
    agc_pga = 4'h3;
    step();
    chk("agc_en", {8'h00, agc_en}, 9'h001);
    chk("lna", {8'h00, lna_max}, 9'h001);
    rdchk(AORB_ADDR_GAIN, 8'h33);
  endtask

  task t_unmapped;
    host.write_reg(7'h6a, 8'hff);
    rdchk(7'h6a, 8'h00);
    rdchk(7'h62, 8'h00);
    rdchk(AORB_ADDR_REGEN, 8'h54);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    rst = 1'b1;
    cal_c = 7'h3a;
    cal_f = 7'h45;
    cal_t = 4'h2;
    agc_lna = 1'b0;
    agc_pga = 4'h4;
    idle = 1'b0;
    auto_en = 9'h000;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_rc();
    t_reg();
    t_adc();
    t_gain();
    t_unmapped();
    complete_run();
  end
endmodule
